//--- tlc_chk.sv
// Port checker for the line code block.
// Bound to tlc_line_code; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tlc_chk (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       txBit,
   input wire logic       rxPos,
   input wire logic       rxNeg,
   input wire logic       rxUnsquelch,
   input wire logic       rxBit,
   input wire logic       rxValid,
   input wire logic [1:0] mltLevel,
   input wire logic       dacLoad,
   input wire logic [5:0] programmableLedOutputsOut,
   input wire logic [5:0] programmableLedOutputsOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence oneAtPos; txBit && mltLevel == 2'h1; endsequence
   sequence oneAtNeg; txBit && mltLevel == 2'h3; endsequence
   // Forced zero allowed: disable and 10M park the line
   AST_MLT_HOLD: assert property (!txBit |=> mltLevel == $past(mltLevel) || mltLevel == 2'h0)
      else $error("level moved on a zero");
   AST_MLT_POS: assert property (oneAtPos |=> mltLevel == 2'h0)
      else $error("plus not followed by zero");
   AST_MLT_NEG: assert property (oneAtNeg |=> mltLevel == 2'h0)
      else $error("minus not followed by zero");
   AST_MLT_LEGAL: assert property (mltLevel != 2'h2)
      else $error("illegal level code");
   AST_RX_DEC: assert property (rxBit |-> $past(rxPos ^ rxNeg))
      else $error("bit without one comparator");
   AST_RX_SQ: assert property (!rxUnsquelch |=> !rxBit && !rxValid)
      else $error("data while squelched");
   AST_DAC_GAP: assert property (dacLoad |=> !dacLoad)
      else $error("sample loads back to back");
   AST_LED_HOLD: assert property ($rose(|programmableLedOutputsOe)
      |-> (|programmableLedOutputsOe) [*8])
      else $error("activity lamp too short");
   AST_LED_OD: assert property (programmableLedOutputsOut == 6'h00)
      else $error("lamp pin driven high");
endmodule
`default_nettype wire

//--- tlc_defs.vh
// Constants for the twisted-pair line code and transmit control block.
// Assumes one 25 MHz clock and a synchronous active-low reset.
//
// Contract
// - Ones step level, zeros hold level
// - Receive three-level back to binary bits
// - Receive data valid only when unsquelched
// - 10M pulse from ROM into DAC
// - 10M idle sends only link pulses
// - Amplitude trim two percent steps, 1000 unity
// - Edge trim minus quarter to plus half
// - Shielded select switches output current
// - LED selects choose transmit, receive or activity
// - Selected LEDs low 100 ms per packet
// - Disable forces idle, no pulses, no loopback
// - Powerdown floats outputs, rest runs
`ifndef TLC_DEFS_VH
`define TLC_DEFS_VH

// Register offsets
`define TLC_REG_CFG        4'h0
`define TLC_REG_LEDSEL     4'h1
`define TLC_REG_STATUS     4'h2
`define TLC_REG_GAIN       4'h3

// Configuration fields
`define TLC_CFG_AMP_LSB    0
`define TLC_CFG_EDGE_LSB   4
`define TLC_CFG_SHIELD     6
`define TLC_CFG_DIS        7
`define TLC_CFG_PDN        8
`define TLC_CFG_SPEED100   9
`define TLC_CFG_LOOP       10
`define TLC_CFG_RESET      11'h008

// LED select codes, two bits per output
`define TLC_LED_OFF        2'h0
`define TLC_LED_TX         2'h1
`define TLC_LED_RX         2'h2
`define TLC_LED_ACT        2'h3

// MLT3 levels
`define TLC_LVL_ZERO       2'h0
`define TLC_LVL_POS        2'h1
`define TLC_LVL_NEG        2'h3

// Timing
`define TLC_CLK_MHZ        25
`define TLC_LED_MS         100
`define TLC_SAMPLE_DIV     2
`define TLC_ROM_DEPTH      16
`define TLC_LINKPULSE_US   16000

`endif

//--- tlc_line_code.v
// Line code and transmit control for a twisted-pair PHY front end.
// Scrambler serial bits arrive one per clock at 100M; comparator outputs are
// synchronous to clk. Registers sit on a plain strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defs.vh"
module tlc_line_code #(
   parameter LED_CYCLES  = `TLC_CLK_MHZ * 1000 * `TLC_LED_MS,
   parameter LINK_CYCLES = `TLC_CLK_MHZ * `TLC_LINKPULSE_US
) (
   input  wire        clk,
   input  wire        reset_n,
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [15:0] regRdData,
   input  wire        txBit,
   input  wire        txActive,
   input  wire        tenBit,
   input  wire        tenActive,
   input  wire        rxPos,
   input  wire        rxNeg,
   input  wire        rxUnsquelch,
   input  wire        rxPacket,
   output reg         rxBit,
   output reg         rxValid,
   output reg  [1:0]  mltLevel,
   output reg  [7:0]  dacSample,
   output reg         dacLoad,
   output wire [3:0]  txAmplitudeTrim,
   output wire [1:0]  txEdgeRateTrim,
   output wire        shieldedMode,
   output wire        txOutEn,
   output wire        loopbackEn,
   output wire [5:0]  programmableLedOutputsOut,
   output wire [5:0]  programmableLedOutputsOe
);
   ////////////////////////////////////////////////////////////////////
   // Registers
   reg [10:0] cfg_q;
   reg [11:0] ledSel_q;
   wire speed100 = cfg_q[`TLC_CFG_SPEED100];
   wire txDis    = cfg_q[`TLC_CFG_DIS];
   wire txPdn    = cfg_q[`TLC_CFG_PDN];
   reg        txLedOn_q;
   reg        rxLedOn_q;

   // Gain in percent for a trim code
   function [7:0] gainPct;
      input [3:0] code;
      begin
         gainPct = 8'h74 - {3'h0, code, 1'b0};
      end
   endfunction

   always @(posedge clk) begin
      if (!reset_n) begin
         cfg_q    <= `TLC_CFG_RESET;
         ledSel_q <= 12'h000;
      end else if (regWrite) begin
         case (regAddr)
            `TLC_REG_CFG:    cfg_q    <= regWrData[10:0];
            `TLC_REG_LEDSEL: ledSel_q <= regWrData[11:0];
            default: ;
         endcase
      end
   end

   always @(posedge clk) begin
      if (!reset_n)
         regRdData <= 16'h0000;
      else if (regRead) begin
         case (regAddr)
            `TLC_REG_CFG:    regRdData <= {5'h00, cfg_q};
            `TLC_REG_LEDSEL: regRdData <= {4'h0, ledSel_q};
            `TLC_REG_STATUS: regRdData <= {11'h000, txLedOn_q, rxLedOn_q,
                                           rxUnsquelch, mltLevel};
            `TLC_REG_GAIN:   regRdData <= {8'h00, gainPct(txAmplitudeTrim)};
            default:         regRdData <= 16'h0000;
         endcase
      end else
         regRdData <= 16'h0000;
   end

   assign txAmplitudeTrim = cfg_q[`TLC_CFG_AMP_LSB +: 4];
   assign txEdgeRateTrim  = cfg_q[`TLC_CFG_EDGE_LSB +: 2];
   assign shieldedMode    = cfg_q[`TLC_CFG_SHIELD];
   assign txOutEn         = ~txPdn;
   assign loopbackEn      = cfg_q[`TLC_CFG_LOOP] & ~txDis;

   ////////////////////////////////////////////////////////////////////
   // 100M MLT3 encoder
   reg [1:0] phase_q;
   always @(posedge clk) begin
      if (!reset_n) begin
         phase_q  <= 2'h0;
         mltLevel <= `TLC_LVL_ZERO;
      end else if (txDis || !speed100) begin
         mltLevel <= `TLC_LVL_ZERO;
      end else if (txBit) begin
         phase_q <= phase_q + 2'h1;
         case (phase_q)
            2'h0:    mltLevel <= `TLC_LVL_POS;
            2'h2:    mltLevel <= `TLC_LVL_NEG;
            default: mltLevel <= `TLC_LVL_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 100M MLT3 decoder
   always @(posedge clk) begin
      if (!reset_n) begin
         rxBit   <= 1'b0;
         rxValid <= 1'b0;
      end else begin
         rxValid <= speed100 & rxUnsquelch;
         // Any nonzero level is a one
         rxBit   <= speed100 & rxUnsquelch & (rxPos ^ rxNeg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 10M waveshaper; bits pass through a pulse replay
   reg  [3:0]  romAddr_q;
   reg         romRun_q;
   reg         romInv_q;
   reg         sampleEn_q;
   reg         loadDly_q;
   localparam DIVW = $clog2(`TLC_SAMPLE_DIV+1);
   reg  [DIVW-1:0] div_q;
   reg  [31:0] linkCnt_q;
   wire [7:0]  romData;
   wire        linkDue = (linkCnt_q == LINK_CYCLES - 1);
   // Idle only link pulses
   // A pulse starts while tenActive is high and no pulse runs; a zero tenBit replays it inverted
   wire        startPulse = !speed100 && !txDis && !romRun_q &&
                            (tenActive || linkDue);

   tlc_wave_rom #(.AW(4), .DW(8)) uRom (
      .clk  (clk),
      .addr (romAddr_q),
      .data (romData)
   );

   always @(posedge clk) begin
      if (!reset_n) begin
         div_q      <= {DIVW{1'b0}};
         sampleEn_q <= 1'b0;
         linkCnt_q  <= 32'h0000_0000;
      end else begin
         sampleEn_q <= (div_q == `TLC_SAMPLE_DIV - 1);
         div_q      <= (div_q == `TLC_SAMPLE_DIV - 1) ? {DIVW{1'b0}} : div_q + 1'b1;
         linkCnt_q  <= (tenActive || linkDue) ? 32'h0000_0000 : linkCnt_q + 32'h1;
      end
   end

   always @(posedge clk) begin
      if (!reset_n) begin
         romAddr_q <= 4'h0;
         romRun_q  <= 1'b0;
         romInv_q  <= 1'b0;
         loadDly_q <= 1'b0;
         dacSample <= 8'h00;
         dacLoad   <= 1'b0;
      end else begin
         loadDly_q <= romRun_q & sampleEn_q;
         dacLoad   <= loadDly_q;
         if (loadDly_q)
            dacSample <= romInv_q ? ~romData : romData;
         else if (!romRun_q)
            dacSample <= 8'h00;
         if (startPulse) begin
            romRun_q  <= 1'b1;
            romAddr_q <= 4'h0;
            romInv_q  <= tenActive & ~tenBit;
         end else if (romRun_q && sampleEn_q) begin
            romAddr_q <= romAddr_q + 4'h1;
            if (romAddr_q == `TLC_ROM_DEPTH - 1)
               romRun_q <= 1'b0;
         end
         if (txDis)
            romRun_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Activity LEDs; retrigger restarts the stretch
   reg [31:0] txLedCnt_q;
   reg [31:0] rxLedCnt_q;
   reg        txWas_q;
   reg        rxWas_q;
   wire       txAny = txActive | tenActive;
   integer k;
   reg [5:0]  ledLow;

   always @(posedge clk) begin
      if (!reset_n) begin
         txLedCnt_q <= 32'h0;
         rxLedCnt_q <= 32'h0;
         txLedOn_q  <= 1'b0;
         rxLedOn_q  <= 1'b0;
         txWas_q    <= 1'b0;
         rxWas_q    <= 1'b0;
      end else begin
         txWas_q <= txAny & ~txDis;
         rxWas_q <= rxPacket;
         if (txAny && !txDis && !txWas_q) begin
            txLedCnt_q <= LED_CYCLES - 1;
            txLedOn_q  <= 1'b1;
         end else if (txLedCnt_q != 32'h0)
            txLedCnt_q <= txLedCnt_q - 32'h1;
         else
            txLedOn_q <= 1'b0;
         if (rxPacket && !rxWas_q) begin
            rxLedCnt_q <= LED_CYCLES - 1;
            rxLedOn_q  <= 1'b1;
         end else if (rxLedCnt_q != 32'h0)
            rxLedCnt_q <= rxLedCnt_q - 32'h1;
         else
            rxLedOn_q <= 1'b0;
      end
   end

   always @* begin
      ledLow = 6'h00;
      for (k = 0; k < 6; k = k + 1) begin
         case (ledSel_q[2*k +: 2])
            `TLC_LED_TX:  ledLow[k] = txLedOn_q;
            `TLC_LED_RX:  ledLow[k] = rxLedOn_q;
            `TLC_LED_ACT: ledLow[k] = txLedOn_q | rxLedOn_q;
            default:      ledLow[k] = 1'b0;
         endcase
      end
   end

   // Open drain: drive low only
   assign programmableLedOutputsOut = 6'h00;
   assign programmableLedOutputsOe  = ledLow;
endmodule
`default_nettype wire

//--- tlc_line_code_bench.sv
// Bench for the line code block: registers, MLT3, receive, 10M, lamps.
// Link model on the receive pins; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tlc_line_code_bench;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 1'b0, regRead = 1'b0, txBit = 1'b0, txActive = 1'b0;
   logic        tenBit = 1'b0, tenActive = 1'b0, rxPacket = 1'b0, sendOn = 1'b0;
   logic        sendBit = 1'b0;
   wire  [15:0] regRdData;
   wire         rxPos, rxNeg, rxUnsq, rxBit, rxValid, dacLoad, shMode, txOutEn, loopEn;
   wire  [1:0]  mltLevel, edgeTrim;
   wire  [7:0]  dacSample;
   wire  [3:0]  ampTrim;
   wire  [5:0]  ledOut, ledOe;
   int          bad_count = 0, n_tests = 0, mP = 0;
   logic [1:0]  mE = 2'h0;
   logic [1:0]  mLv [4] = '{2'h1, 2'h0, 2'h3, 2'h0};
   // Short lamp and link counts keep the run brief
   tlc_line_code #(.LED_CYCLES(20), .LINK_CYCLES(50)) tlc_line_code_inst (
      .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .txBit(txBit),
      .txActive(txActive), .tenBit(tenBit), .tenActive(tenActive), .rxPos(rxPos),
      .rxNeg(rxNeg), .rxUnsquelch(rxUnsq), .rxPacket(rxPacket), .rxBit(rxBit),
      .rxValid(rxValid), .mltLevel(mltLevel), .dacSample(dacSample), .dacLoad(dacLoad),
      .txAmplitudeTrim(ampTrim), .txEdgeRateTrim(edgeTrim), .shieldedMode(shMode),
      .txOutEn(txOutEn), .loopbackEn(loopEn), .programmableLedOutputsOut(ledOut),
      .programmableLedOutputsOe(ledOe));
   tlc_link_model tlc_link_model_inst (.clk(clk), .sendOn(sendOn), .sendBit(sendBit),
      .rxPos(rxPos), .rxNeg(rxNeg), .rxUnsquelch(rxUnsq));
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task automatic final_report;
      $display("Mismatches %0d in %0d checks", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(4'h0, 16'h0008);
      rd(4'hF, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         wr(4'h0, 16'(i + i % 4 * 16 + i % 2 * 64));
         rd(4'h3, 16'(116 - 2 * i));
         chk({edgeTrim, shMode, ampTrim}, 16'(i % 4 * 32 + i % 2 * 16 + i));
      end
   endtask
   // Back-to-back bits; frozen runs must not advance the phase
   task automatic runBits(input logic [7:0] pat, input logic frz);
      for (int i = 0; i <= 8; i++) begin
         @(posedge clk);
         txBit <= (i < 8) ? pat[i] : 1'b0;
         if (i > 0 && pat[i-1] && !frz) begin
            mE = mLv[mP];
            mP = (mP + 1) % 4;
         end
         #1 if (i > 0) chk(mltLevel, frz ? 2'h0 : mE);
      end
   endtask
   task automatic t_mlt;
      wr(4'h0, 16'h0608);
      chk(loopEn, 1'b1);
      runBits(8'hDB, 1'b0);
      wr(4'h0, 16'h0688);
      chk(loopEn, 1'b0);
      runBits(8'hFF, 1'b1);
      wr(4'h0, 16'h0208);
      runBits(8'h2F, 1'b0);
   endtask
   task automatic t_rx;
      logic [1:0] ex;
      ex = 2'h0;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         sendOn <= (i < 12);
         sendBit <= i[0] ^ i[2];
         #1 if (i > 0) chk({rxValid, rxBit}, ex);
         ex = {rxUnsq, rxUnsq & (rxPos ^ rxNeg)};
      end
   endtask
   task automatic ledRun(input logic isRx, input logic [5:0] e);
      @(posedge clk);
      txActive <= !isRx;
      rxPacket <= isRx;
      repeat (3) @(posedge clk);
      txActive <= 1'b0;
      rxPacket <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(ledOe, e);
      chk(ledOut, 6'h00);
      repeat (25) @(posedge clk);
      #1 chk(ledOe, 6'h00);
   endtask
   task automatic cntLoads(input int c, output int n);
      n = 0;
      repeat (c) begin
         @(posedge clk);
         #1 if (dacLoad === 1'b1) n++;
      end
   endtask
   task automatic t_ten;
      int n;
      wr(4'h0, 16'h0088);
      cntLoads(120, n);
      chk(16'(n), 16'h0000);
      wr(4'h0, 16'h0008);
      cntLoads(120, n);
      chk({n >= 16, n <= 48}, 2'h3);
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         tenActive <= 1'b1;
         tenBit <= b[0];
         cntLoads(80, n);
         chk(n >= 16, 1'b1);
      end
      @(posedge clk);
      tenActive <= 1'b0;
      tenBit <= 1'b0;
      wr(4'h0, 16'h0088);
      repeat (4) @(posedge clk);
      #1 chk(dacSample, 16'h0000);
   endtask
   task automatic t_pdn;
      wr(4'h0, 16'h0108);
      chk(txOutEn, 1'b0);
      rd(4'h0, 16'h0108);
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      rd(4'h0, 16'h0008);
      chk(txOutEn, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      chk(txOutEn, 1'b1);
      t_regs();
      t_mlt();
      wr(4'h0, 16'h0208);
      t_rx();
      wr(4'h1, 16'h0D39);
      ledRun(1'b0, 6'h35);
      ledRun(1'b1, 6'h26);
      rd(4'h2, {14'h0000, mE});
      t_ten();
      t_pdn();
      final_report();
   end
endmodule
bind tlc_line_code tlc_chk tlc_chk_inst (.clk(clk), .reset_n(reset_n), .txBit(txBit),
   .rxPos(rxPos), .rxNeg(rxNeg), .rxUnsquelch(rxUnsquelch), .rxBit(rxBit),
   .rxValid(rxValid), .mltLevel(mltLevel), .dacLoad(dacLoad),
   .programmableLedOutputsOut(programmableLedOutputsOut),
   .programmableLedOutputsOe(programmableLedOutputsOe));
`default_nettype wire

//--- tlc_link_model.sv
// Far-end link partner driving the comparator outputs.
// Squelched line shows toggling noise so a leaky gate shows up.
`timescale 1ns/1ps
`default_nettype none
module tlc_link_model (
   input  wire logic clk,
   input  wire logic sendOn,
   input  wire logic sendBit,
   output var  logic rxPos,
   output var  logic rxNeg,
   output var  logic rxUnsquelch
);
   logic [1:0] phase_q = 2'h0;
   logic       noise_q = 1'b0;
   wire  [1:0] phase_d = phase_q + {1'b0, sendBit};
   initial begin
      rxPos = 1'b0;
      rxNeg = 1'b0;
      rxUnsquelch = 1'b0;
   end
   always @(posedge clk) begin
      noise_q <= ~noise_q;
      rxUnsquelch <= sendOn;
      phase_q <= sendOn ? phase_d : phase_q;
      rxPos <= sendOn ? (phase_d == 2'h1) : noise_q;
      rxNeg <= sendOn ? (phase_d == 2'h3) : ~noise_q;
   end
endmodule
`default_nettype wire

//--- tlc_wave_rom.v
// Waveform sample ROM for 10 Mbit/s pulse shaping.
// Read data registered; one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module tlc_wave_rom #(
   parameter AW = 4,
   parameter DW = 8
) (
   input  wire          clk,
   input  wire [AW-1:0] addr,
   output reg  [DW-1:0] data
);
   reg [DW-1:0] rom [0:(1<<AW)-1];
   integer i;
   // Half-sine stair of a single pulse
   initial begin
      for (i = 0; i < (1<<AW); i = i + 1)
         rom[i] = 8'h00;
      rom[0] = 8'h20; rom[1] = 8'h60; rom[2] = 8'hA0; rom[3] = 8'hD8;
      rom[4] = 8'hF8; rom[5] = 8'hFF; rom[6] = 8'hF0; rom[7] = 8'hC8;
      rom[8] = 8'h90; rom[9] = 8'h58; rom[10] = 8'h28; rom[11] = 8'h08;
   end
   always @(posedge clk) begin
      data <= rom[addr];
   end
endmodule
`default_nettype wire
